/* rtl/dlbs_pkg.sv */
// package: constants for the deterministic latency bit-slip channel logic
package dlbs_pkg;
  localparam int          SLIP_W        = 5;
  localparam int          SW_WIDTH      = 10;
  localparam int          DW_WIDTH      = 20;
  localparam logic [4:0]  SW_SLIP_MAX   = 5'h09;
  localparam logic [4:0]  DW_SLIP_MAX   = 5'h13;
  localparam logic [4:0]  DW_REPORT_TOP = 5'h13;
  localparam logic [4:0]  SLIP_RST      = 5'h00;
  localparam logic [19:0] WORD_RST      = 20'h00000;
  localparam logic [4:0]  BIT_LAST_SW   = 5'h09;
  localparam logic [4:0]  BIT_LAST_DW   = 5'h13;
  localparam int          REG_LATENCY   = 1;
  typedef enum logic [2:0] {
    DLBS_SER_IDLE = 3'b001,
    DLBS_SER_LOAD = 3'b010,
    DLBS_SER_SHIFT = 3'b100
  } dlbs_ser_t;
endpackage

/* rtl/dlbs_channel.sv */
// module: one deterministic latency channel: slip, report, register-mode fifos, idle
`timescale 1ns/1ns
`default_nettype none

// Operation
// RULE1: forced idle tri-states the transmit output buffer for as long as held high.
// RULE2: outside logic keeps clock recovery locked to reference during out-of-band signalling.
// RULE3: level-detect output only active when 8b/10b coding is selected.
// RULE4: level-detect high when sensed level exceeds threshold, low otherwise.
// RULE5: deterministic mode forces transmit bit-slip and receive fifo register mode; here receive register mode only when NARROW_WIDTH equals CODER_EN.
// RULE6: five-bit transmit slip input and five-bit receive slip report.
// RULE7: transmit serial output slipped by the slip-amount number of bits.
// RULE8: outside logic limits slip to 9 or 19 bits by width.
// RULE9: single width reports binary count of slipped bits.
// RULE10: double width reports nineteen minus slipped bits.
// RULE11: outside logic uses report to choose transmit slip, cancelling latency.
// RULE12: receive register mode passes data with one cycle latency.
// RULE13: single-width register mode needs 8-bit plus coding or 10-bit bypassed.
// RULE14: double-width register mode needs 16-bit plus coding or 20-bit bypassed.
// RULE15: transmit register mode passes data with one cycle latency.
// RULE16: feedback compensation selects fixed-phase parallel clock to reference relation.
// RULE17: system supplies reference clock equal to parallel clock frequency.
// RULE18: each channel takes one channel_clock_pll; aux_transmit_pll cannot serve.
// RULE19: up to four transmit channels may bundle on one shared pll.
// RULE20: fabric oversamples bundled low-rate channels and skips hard coder.
// RULE21: new slip amount applies only from the next serialized word.
module dlbs_channel (
  input  wire logic        SYS_CLK,
  input  wire logic        RSTN,
  input  wire logic        DET_LAT_EN,
  input  wire logic        DOUBLE_WIDTH,
  input  wire logic        CODER_EN,
  input  wire logic        NARROW_WIDTH,
  input  wire logic        TX_REG_MODE_REQ,
  input  wire logic        RX_REG_MODE_REQ,
  input  wire logic        FEEDBACK_EN,
  input  wire logic        PLL_IS_AUX,
  input  wire logic [1:0]  BUNDLE_SIZE,
  input  wire logic        TX_IDLE_FORCE,
  input  wire logic [4:0]  TX_SLIP_AMOUNT,
  input  wire logic [19:0] TX_WORD,
  input  wire logic        TX_WORD_VALID,
  output logic             TX_WORD_READY,
  output logic             TX_SERIAL,
  output logic             TX_SERIAL_OE,
  input  wire logic        RX_LEVEL_ABOVE,
  input  wire logic [4:0]  RX_ALIGNER_SLIP,
  input  wire logic [19:0] RX_WORD_IN,
  output logic [19:0]      RX_WORD_OUT,
  output logic             RX_LEVEL_DETECT,
  output logic [4:0]       RX_SLIP_REPORT,
  output logic             RX_REG_MODE,
  output logic             TX_REG_MODE,
  output logic             TX_BITSLIP_MODE,
  output logic             FEEDBACK_ACTIVE,
  output logic             CONFIG_ERROR
);
  logic             idle_s1;
  logic             idle_s2;
  logic             lvl_s1;
  logic             lvl_s2;
  logic [4:0]       rslip_s1;
  logic [4:0]       rslip_s2;
  logic [19:0]      rx_s1;
  logic [19:0]      rx_s2;
  logic [19:0]      tx_reg;
  logic [19:0]      shifter;
  logic [4:0]       bit_idx;
  logic [4:0]       word_slip;
  logic [4:0]       last_bit;
  logic [4:0]       slip_lim;
  logic             rx_reg_ok;
  logic             tx_have;
  logic [4:0]       tx_pick;
  logic             err_aux;
  logic             err_width;
  logic             err_bundle;
  dlbs_pkg::dlbs_ser_t state;
  dlbs_pkg::dlbs_ser_t next_state;

  // pin-side inputs pass two flops before use
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      idle_s1 <= 1'b0;
      idle_s2 <= 1'b0;
    end else begin
      idle_s1 <= TX_IDLE_FORCE;
      idle_s2 <= idle_s1;
    end
  end

  // level input changes slowly, so two flops suffice
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      lvl_s1 <= 1'b0;
      lvl_s2 <= 1'b0;
    end else begin
      lvl_s1 <= RX_LEVEL_ABOVE;
      lvl_s2 <= lvl_s1;
    end
  end

  // slip count is quasi-static, so per-bit sync is safe once it settles
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rslip_s1 <= dlbs_pkg::SLIP_RST;
      rslip_s2 <= dlbs_pkg::SLIP_RST;
    end else begin
      rslip_s1 <= RX_ALIGNER_SLIP;
      rslip_s2 <= rslip_s1;
    end
  end

  // word bits sync alone; a word caught mid-change may tear for one cycle
  for (genvar b = 0; b < dlbs_pkg::DW_WIDTH; b++) begin : g_rx_sync
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
        rx_s1[b] <= dlbs_pkg::WORD_RST[b];
        rx_s2[b] <= dlbs_pkg::WORD_RST[b];
      end else begin
        rx_s1[b] <= RX_WORD_IN[b];
        rx_s2[b] <= rx_s1[b];
      end
    end
  end

  // allowed register-mode width/coding pairs
  assign rx_reg_ok = (NARROW_WIDTH == CODER_EN); // see RULE13 see RULE14
  assign RX_REG_MODE = (DET_LAT_EN | RX_REG_MODE_REQ) & rx_reg_ok; // see RULE5 see RULE12
  assign TX_REG_MODE = DET_LAT_EN | TX_REG_MODE_REQ; // see RULE5 see RULE15
  assign TX_BITSLIP_MODE = DET_LAT_EN; // see RULE5
  // aux plls have no feedback path, so they never give fixed phase
  assign FEEDBACK_ACTIVE = FEEDBACK_EN & ~PLL_IS_AUX; // see RULE16 see RULE18
  assign err_aux = DET_LAT_EN & PLL_IS_AUX; // see RULE18
  assign err_width = DET_LAT_EN & ~rx_reg_ok; // see RULE13 see RULE14
  // bundling only makes sense under a shared deterministic pll
  assign err_bundle = (BUNDLE_SIZE != 2'h0) & ~DET_LAT_EN; // see RULE19
  assign CONFIG_ERROR = err_aux | err_width | err_bundle;

  // receive path: exactly one flop after sync, whether or not register mode is set
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      RX_WORD_OUT <= dlbs_pkg::WORD_RST;
    end else begin
      RX_WORD_OUT <= rx_s2; // see RULE12
    end
  end

  // without coder select the detector is not offered, so it reads low
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      RX_LEVEL_DETECT <= 1'b0;
    end else begin
      RX_LEVEL_DETECT <= lvl_s2 & CODER_EN; // see RULE3 see RULE4
    end
  end

  // report clears outside the mode so a stale count never lingers
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      RX_SLIP_REPORT <= dlbs_pkg::SLIP_RST;
    end else if (!DET_LAT_EN) begin
      RX_SLIP_REPORT <= dlbs_pkg::SLIP_RST; // see RULE6
    end else if (DOUBLE_WIDTH) begin
      RX_SLIP_REPORT <= dlbs_pkg::DW_REPORT_TOP - rslip_s2; // see RULE10
    end else begin
      RX_SLIP_REPORT <= rslip_s2; // see RULE9
    end
  end

  // transmit register stage, one cycle
  // ready returns in load so words may run back to back
  assign TX_WORD_READY = ~tx_have | (state == dlbs_pkg::DLBS_SER_LOAD);
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      tx_reg <= dlbs_pkg::WORD_RST;
    end else if (TX_WORD_VALID && TX_WORD_READY) begin
      tx_reg <= TX_WORD; // see RULE15
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      tx_have <= 1'b0;
    end else if (TX_WORD_VALID && TX_WORD_READY) begin
      tx_have <= 1'b1;
    end else if (state == dlbs_pkg::DLBS_SER_LOAD) begin
      tx_have <= 1'b0;
    end
  end

  assign last_bit = DOUBLE_WIDTH ? dlbs_pkg::BIT_LAST_DW : dlbs_pkg::BIT_LAST_SW;
  assign slip_lim = DOUBLE_WIDTH ? dlbs_pkg::DW_SLIP_MAX : dlbs_pkg::SW_SLIP_MAX;

  always_comb begin
    next_state = state;
    case (state)
      dlbs_pkg::DLBS_SER_IDLE: begin
        if (tx_have) begin
          next_state = dlbs_pkg::DLBS_SER_LOAD;
        end
      end
      dlbs_pkg::DLBS_SER_LOAD: begin
        next_state = dlbs_pkg::DLBS_SER_SHIFT;
      end
      dlbs_pkg::DLBS_SER_SHIFT: begin
        if (bit_idx == last_bit) begin
          next_state = tx_have ? dlbs_pkg::DLBS_SER_LOAD : dlbs_pkg::DLBS_SER_IDLE;
        end
      end
      default: begin
        // illegal codes fall back to idle
        next_state = dlbs_pkg::DLBS_SER_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state <= dlbs_pkg::DLBS_SER_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // slip latched only at word load, so a mid-word change cannot tear a word
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      word_slip <= dlbs_pkg::SLIP_RST;
    end else if (state == dlbs_pkg::DLBS_SER_LOAD) begin
      if (!DET_LAT_EN) begin
        word_slip <= dlbs_pkg::SLIP_RST;
      end else if (TX_SLIP_AMOUNT > slip_lim) begin
        word_slip <= slip_lim; // out-of-range amount clamped, see RULE8
      end else begin
        word_slip <= TX_SLIP_AMOUNT; // see RULE21 see RULE6
      end
    end
  end

  // serializer: rotate word by slip so output starts slip bits late
  // word held whole here while tx_reg refills behind it
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      shifter <= dlbs_pkg::WORD_RST;
    end else if (state == dlbs_pkg::DLBS_SER_LOAD) begin
      shifter <= tx_reg;
    end
  end

  // index wraps at the last bit even when idle follows
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      bit_idx <= 5'h00;
    end else if (state == dlbs_pkg::DLBS_SER_LOAD) begin
      bit_idx <= 5'h00;
    end else if (state == dlbs_pkg::DLBS_SER_SHIFT) begin
      bit_idx <= (bit_idx == last_bit) ? 5'h00 : bit_idx + 5'h01;
    end
  end

  // rotated pick keeps the slip inside one word rather than across words
  assign tx_pick = sel_bit(bit_idx, word_slip, last_bit);

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      TX_SERIAL <= 1'b0;
    end else if (state == dlbs_pkg::DLBS_SER_SHIFT) begin
      // bit position = (idx + width - slip) mod width
      TX_SERIAL <= shifter[tx_pick]; // see RULE7
    end else begin
      // line idles low between words
      TX_SERIAL <= 1'b0;
    end
  end

  // slip never above the last bit here; the load clamps it
  function automatic logic [4:0] sel_bit(input logic [4:0] idx,
                                         input logic [4:0] slp,
                                         input logic [4:0] lst);
    logic [5:0] sum;
    sum = {1'b0, idx} + {1'b0, lst} + 6'h01 - {1'b0, slp};
    if (sum > {1'b0, lst}) begin
      sum = sum - ({1'b0, lst} + 6'h01);
    end
    sel_bit = sum[4:0];
  endfunction

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      TX_SERIAL_OE <= 1'b0;
    end else begin
      // oe low is electrical idle: the pin floats
      TX_SERIAL_OE <= ~idle_s2; // see RULE1
    end
  end
endmodule

`default_nettype wire

/* bench/dlbs_checker.sv */
// port-level assertions for the deterministic latency channel
`timescale 1ns/1ns
`default_nettype none
module dlbs_checker (
  input wire logic        SYS_CLK, RSTN, DET_LAT_EN, DOUBLE_WIDTH, CODER_EN, NARROW_WIDTH,
  input wire logic        PLL_IS_AUX, TX_IDLE_FORCE, RX_LEVEL_ABOVE, TX_SERIAL_OE,
  input wire logic        RX_LEVEL_DETECT, RX_REG_MODE, TX_REG_MODE, TX_BITSLIP_MODE,
  input wire logic        FEEDBACK_ACTIVE, CONFIG_ERROR,
  input wire logic [1:0]  BUNDLE_SIZE,
  input wire logic [4:0]  RX_ALIGNER_SLIP, RX_SLIP_REPORT,
  input wire logic [19:0] RX_WORD_IN, RX_WORD_OUT
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  logic [1:0] up;
  logic [3:0] cfg;
  // three-edge paths compare only once flushed; level and report paths also need config held
  assign cfg = {DET_LAT_EN, DOUBLE_WIDTH, CODER_EN, NARROW_WIDTH};
  always_ff @(posedge SYS_CLK or negedge RSTN)
    if (!RSTN) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;
  AST_IDLE: assert property (up == 2'h3 |-> TX_SERIAL_OE == !$past(TX_IDLE_FORCE, 3))
    else $error("output enable does not follow idle force");
  AST_LEVEL: assert property (up == 2'h3 && cfg == $past(cfg, 3)
    |-> RX_LEVEL_DETECT == ($past(RX_LEVEL_ABOVE, 3) && CODER_EN)) else $error("level detect wrong");
  AST_RX_REG: assert property (up == 2'h3 |-> RX_WORD_OUT == $past(RX_WORD_IN, 3))
    else $error("receive word latency wrong");
  AST_SW_RPT: assert property (up == 2'h3 && cfg == $past(cfg, 3) && DET_LAT_EN && !DOUBLE_WIDTH
    |-> RX_SLIP_REPORT == $past(RX_ALIGNER_SLIP, 3)) else $error("single width report wrong");
  AST_DW_RPT: assert property (up == 2'h3 && cfg == $past(cfg, 3) && DET_LAT_EN && DOUBLE_WIDTH
    |-> RX_SLIP_REPORT == 5'h13 - $past(RX_ALIGNER_SLIP, 3)) else $error("double width report wrong");
  AST_MODES: assert property (DET_LAT_EN && !PLL_IS_AUX && NARROW_WIDTH == CODER_EN
    |-> TX_BITSLIP_MODE && RX_REG_MODE && TX_REG_MODE) else $error("modes not forced");
  AST_REG_OK: assert property (RX_REG_MODE |-> NARROW_WIDTH == CODER_EN)
    else $error("register mode in bad width");
  AST_AUX: assert property (PLL_IS_AUX |-> !FEEDBACK_ACTIVE && (CONFIG_ERROR || !DET_LAT_EN))
    else $error("aux pll accepted");
  AST_BUNDLE: assert property (BUNDLE_SIZE != 2'h0 && !DET_LAT_EN |-> CONFIG_ERROR)
    else $error("bundle accepted");
endmodule
bind dlbs_channel dlbs_checker chk_u (.*);
`default_nettype wire

/* bench/dlbs_partner.sv */
// fabric-side partner: offers transmit words, limits slip, drives pin words
`timescale 1ns/1ns
`default_nettype none
module dlbs_partner (
  input  wire logic        clk, go, dw, ready,
  input  wire logic [4:0]  slip_req,
  input  wire logic [19:0] word,
  output logic             valid = '0,
  output logic [19:0]      data = '0,
  output logic [19:0]      rx_word = '0,
  output logic [4:0]       slip
);
  // clamp here so the device never sees an illegal slip
  assign slip = dw ? (slip_req > dlbs_pkg::DW_SLIP_MAX ? dlbs_pkg::DW_SLIP_MAX : slip_req)
                   : (slip_req > dlbs_pkg::SW_SLIP_MAX ? dlbs_pkg::SW_SLIP_MAX : slip_req);
  // reference is this same clock, one word per parallel cycle
  // recovery stays locked to reference outside this model
  // no bundling here, so no oversampled word meets the coder
  always @(posedge clk) begin
    if (go && !valid) begin
      valid <= #1 '1;
      data <= #1 word;
    end else if (valid && ready) valid <= #1 '0;
    rx_word <= #1 rx_word + 20'h1;
  end
endmodule
`default_nettype wire

/* bench/dlbs_channel_tb.sv */
// self-checking bench for the deterministic latency channel
`timescale 1ns/1ns
`default_nettype none
module dlbs_channel_tb;
  typedef struct packed {logic dw; logic [4:0] slip, aslip, rpt; logic [19:0] word;} dlbs_row_t;
  logic SYS_CLK = '0, RSTN = '0, DET_LAT_EN = '1, DOUBLE_WIDTH = '0, CODER_EN = '0;
  logic NARROW_WIDTH = '0, TX_REG_MODE_REQ = '0, RX_REG_MODE_REQ = '0, FEEDBACK_EN = '1;
  logic PLL_IS_AUX = '0, TX_IDLE_FORCE = '0, RX_LEVEL_ABOVE = '0, go = '0;
  logic [1:0] BUNDLE_SIZE = '0;
  logic [4:0] RX_ALIGNER_SLIP = '0, slip_req = '0, TX_SLIP_AMOUNT, RX_SLIP_REPORT;
  logic [19:0] word = '0, TX_WORD, RX_WORD_IN, RX_WORD_OUT;
  logic TX_WORD_VALID, TX_WORD_READY, TX_SERIAL, TX_SERIAL_OE, RX_LEVEL_DETECT;
  logic RX_REG_MODE, TX_REG_MODE, TX_BITSLIP_MODE, FEEDBACK_ACTIVE, CONFIG_ERROR;
  int bad_count = 0, check_count = 0;
  dlbs_row_t rows [6] = '{'{1'h0, 5'h00, 5'h00, 5'h00, 20'h002a5},
    '{1'h0, 5'h03, 5'h02, 5'h02, 20'h0035b}, '{1'h0, 5'h09, 5'h09, 5'h09, 20'h00171},
    '{1'h1, 5'h00, 5'h00, 5'h13, 20'h5a3c1}, '{1'h1, 5'h07, 5'h02, 5'h11, 20'h0f0f3},
    '{1'h1, 5'h13, 5'h13, 5'h00, 20'hc3a5e}};
  dlbs_channel dut_u (.*);
  dlbs_partner ptn_u (.clk(SYS_CLK), .go(go), .dw(DOUBLE_WIDTH), .ready(TX_WORD_READY),
    .slip_req(slip_req), .word(word), .valid(TX_WORD_VALID), .data(TX_WORD),
    .rx_word(RX_WORD_IN), .slip(TX_SLIP_AMOUNT));
  task cmp(input logic [19:0] got, input logic [19:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task step(input int n);
    repeat (n) @(posedge SYS_CLK);
    #1;
  endtask
  // a late slip change must leave the word in flight alone
  task automatic send(input dlbs_row_t r, input logic chg);
    int w;
    logic [19:0] got, exp;
    w = r.dw ? 20 : 10;
    got = '0;
    exp = '0;
    DOUBLE_WIDTH = r.dw;
    RX_ALIGNER_SLIP = r.aslip;
    slip_req = r.slip;
    word = r.word;
    go = '1;
    @(posedge SYS_CLK iff (TX_WORD_VALID && TX_WORD_READY));
    #1 go = '0;
    repeat (3) @(posedge SYS_CLK);
    for (int k = 0; k < w; k++) begin
      #10 got[k] = TX_SERIAL;
      exp[k] = r.word[(k + w - r.slip) % w];
      if (chg && k == 1) slip_req = 5'h05;
      @(posedge SYS_CLK);
    end
    #1 cmp(got, exp);
    cmp(RX_SLIP_REPORT, r.rpt);
  endtask
  initial forever #50 SYS_CLK = ~SYS_CLK;
  initial begin
    #200000 bad_count++;
    print_verdict;
  end
  initial begin
    step(8);
    RSTN = '1;
    step(4);
    foreach (rows[i]) send(rows[i], '0);
    send(rows[1], '1);
    $display("test slip table done");
    TX_IDLE_FORCE = '1;
    step(4);
    cmp(TX_SERIAL_OE, '0);
    TX_IDLE_FORCE = '0;
    step(4);
    cmp(TX_SERIAL_OE, 20'h1);
    $display("test idle done");
    CODER_EN = '1;
    NARROW_WIDTH = '1;
    RX_LEVEL_ABOVE = '1;
    step(4);
    cmp(RX_LEVEL_DETECT, 20'h1);
    cmp(RX_REG_MODE, 20'h1);
    RX_LEVEL_ABOVE = '0;
    step(4);
    cmp(RX_LEVEL_DETECT, '0);
    RX_LEVEL_ABOVE = '1;
    CODER_EN = '0;
    step(4);
    cmp(RX_LEVEL_DETECT, '0);
    cmp(CONFIG_ERROR, 20'h1);
    NARROW_WIDTH = '0;
    $display("test level done");
    PLL_IS_AUX = '1;
    step(1);
    cmp(CONFIG_ERROR, 20'h1);
    cmp(FEEDBACK_ACTIVE, '0);
    PLL_IS_AUX = '0;
    step(1);
    cmp({TX_BITSLIP_MODE, RX_REG_MODE, TX_REG_MODE}, 20'h7);
    DET_LAT_EN = '0;
    BUNDLE_SIZE = 2'h3;
    step(4);
    cmp(CONFIG_ERROR, 20'h1);
    cmp(RX_SLIP_REPORT, '0);
    DET_LAT_EN = '1;
    step(1);
    cmp(CONFIG_ERROR, '0);
    $display("test config done");
    RSTN = '0;
    step(2);
    cmp({TX_SERIAL_OE, RX_WORD_OUT}, '0);
    RSTN = '1;
    step(4);
    $display("test reset done");
    print_verdict;
  end
endmodule
`default_nettype wire
